// *** rtl/cpu_operand_address_decoder.sv ***
`default_nettype none
`include "opdec_defines.svh"
module cpu_operand_address_decoder (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Opcode from fetch unit, already classified
    input  wire logic                  op_valid,
    output logic                       op_ready,
    input  wire opdec_pkg::addr_mode_t op_mode,
    input  wire opdec_pkg::inh_op_t    op_inh,
    input  wire logic                  op_rmw,
    input  wire logic                  op_use_y,
    // Instruction bytes following the opcode
    input  wire logic                  byte_valid,
    output logic                       byte_ready,
    input  wire logic [7:0]            byte_data,
    // Index registers
    input  wire logic [7:0]            index_x,
    input  wire logic [7:0]            index_y,
    // Pointer read on data memory
    output logic                       ptr_req,
    output logic [15:0]                ptr_addr,
    input  wire logic                  ptr_ack,
    input  wire logic [7:0]            ptr_data,
    // Decoded result
    output logic                       res_valid,
    output logic                       res_is_imm,
    output logic                       res_is_addr,
    output logic [15:0]                res_addr,
    output logic [7:0]                 res_imm,
    output logic                       res_illegal,
    // Core control effects
    output logic [1:0]                 int_mask,
    output logic                       osc_stop
);
    opdec_pkg::dec_state_t state;
    opdec_pkg::dec_state_t next_state;
    opdec_pkg::addr_mode_t mode;
    logic        use_y;
    logic        wide;
    logic [7:0]  ptr_loc;
    logic [15:0] word;
    logic        load_hi;
    logic        load_lo;

    // Unsigned index plus offset, carry kept in bit 8 and up
    function automatic logic [15:0] idx_add(input logic [7:0] idx, input logic [15:0] off);
        idx_add = off + {`PAGE_ZERO_HI, idx};
    endfunction

    // Operand byte count after the opcode
    wire       mode_two  = (op_mode == opdec_pkg::mode_dir_long)
                           || (op_mode == opdec_pkg::mode_idx_long);
    wire       mode_none = (op_mode == opdec_pkg::mode_inherent)
                           || (op_mode == opdec_pkg::mode_idx_none);
    // Long modes and immediate on read-modify-write ops are refused
    wire       rmw_bad   = op_rmw && (mode_two || op_mode == opdec_pkg::mode_ind_long
                           || op_mode == opdec_pkg::mode_immediate);
    wire       take_op   = op_valid && op_ready;
    wire       take_byte = byte_valid && byte_ready;
    wire       ptr_take  = ptr_req && ptr_ack;
    wire       is_ind    = (mode == opdec_pkg::mode_ind_short) || (mode == opdec_pkg::mode_ind_long);
    wire       refuse    = take_op && rmw_bad;
    // Opcode-only results form at the opcode edge, before mode and index choice are captured
    opdec_pkg::addr_mode_t cur_mode;
    assign cur_mode = take_op ? op_mode : mode;
    wire       cur_y     = take_op ? op_use_y : use_y;
    wire [7:0] idx_val   = cur_y ? index_y : index_x;
    // Only the long indirect reads a second pointer byte, one location up
    wire       ptr_next  = (state == opdec_pkg::st_ptr_lo) && (mode == opdec_pkg::mode_ind_long);

    assign op_ready   = (state == opdec_pkg::st_idle);
    assign byte_ready = (state == opdec_pkg::st_byte1) || (state == opdec_pkg::st_byte2);
    assign ptr_req    = (state == opdec_pkg::st_ptr_hi) || (state == opdec_pkg::st_ptr_lo);
    assign ptr_addr   = ptr_next ? ({`PAGE_ZERO_HI, ptr_loc} + `PTR_NEXT)
                                 : {`PAGE_ZERO_HI, ptr_loc};
    // First byte of a two-byte operand, or the pointer high byte, opens a word
    assign load_hi = (take_byte && state == opdec_pkg::st_byte1 && wide)
                  || (ptr_take && state == opdec_pkg::st_ptr_hi);
    assign load_lo = (take_byte && state == opdec_pkg::st_byte2)
                  || (ptr_take && state == opdec_pkg::st_ptr_lo);
    // The byte landing at this edge is used at once, so a result never sees stale bytes
    wire [7:0]  asm_byte = (is_ind && ptr_req) ? ptr_data : byte_data;
    wire [7:0]  loc_now  = (take_byte && state == opdec_pkg::st_byte1) ? byte_data : ptr_loc;
    wire [15:0] word_now = load_lo ? {word[15:8], asm_byte} : word;

    word_assemble u_word (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .load_hi  (load_hi),
        .load_lo  (load_lo),
        .data_in  (asm_byte),
        .word_out (word)
    );

    // Sequencer over opcode, operand bytes and pointer reads
    always_comb
    begin
        next_state = state;
        unique case (state)
            opdec_pkg::st_idle:
                if (take_op)
                    next_state = (mode_none || rmw_bad) ? opdec_pkg::st_done : opdec_pkg::st_byte1;
            opdec_pkg::st_byte1:
                if (take_byte)
                begin
                    if (wide)
                        next_state = opdec_pkg::st_byte2;
                    else if (is_ind)
                        next_state = (mode == opdec_pkg::mode_ind_long) ? opdec_pkg::st_ptr_hi
                                                                        : opdec_pkg::st_ptr_lo;
                    else
                        next_state = opdec_pkg::st_done;
                end
            opdec_pkg::st_byte2:
                if (take_byte)
                    next_state = opdec_pkg::st_done;
            opdec_pkg::st_ptr_hi:
                if (ptr_take)
                    next_state = opdec_pkg::st_ptr_lo;
            opdec_pkg::st_ptr_lo:
                if (ptr_take)
                    next_state = opdec_pkg::st_done;
            opdec_pkg::st_done:
                next_state = opdec_pkg::st_idle;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= opdec_pkg::st_idle;
        else
            state <= next_state;
    end

    // Capture of mode, index choice and word width at opcode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode  <= opdec_pkg::mode_inherent;
            use_y <= 1'b0;
            wide  <= 1'b0;
        end
        else if (take_op)
        begin
            mode  <= op_mode;
            use_y <= op_use_y;
            wide  <= mode_two;
        end
    end

    // Pointer location is the byte right after the opcode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ptr_loc <= `BYTE_ZERO;
        else if (take_byte && state == opdec_pkg::st_byte1)
            ptr_loc <= byte_data;
    end

    // Effective address per mode; short direct and indirect forms zero the high byte, short indexed keeps the carry
    logic [15:0] eff_addr;
    always_comb
    begin
        eff_addr = `ADDR_ZERO;
        unique case (cur_mode)
            opdec_pkg::mode_dir_short: eff_addr = {`PAGE_ZERO_HI, loc_now};
            opdec_pkg::mode_dir_long:  eff_addr = word_now;
            opdec_pkg::mode_idx_none:  eff_addr = {`PAGE_ZERO_HI, idx_val};
            opdec_pkg::mode_idx_short: eff_addr = idx_add(idx_val, {`PAGE_ZERO_HI, loc_now});
            opdec_pkg::mode_idx_long:  eff_addr = idx_add(idx_val, word_now);
            opdec_pkg::mode_ind_short: eff_addr = {`PAGE_ZERO_HI, word_now[7:0]};
            opdec_pkg::mode_ind_long:  eff_addr = word_now;
            default:                   eff_addr = `ADDR_ZERO;
        endcase
    end

    // Result register, one-cycle valid in the done state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            res_valid   <= 1'b0;
            res_is_imm  <= 1'b0;
            res_is_addr <= 1'b0;
            res_addr    <= `ADDR_ZERO;
            res_imm     <= `BYTE_ZERO;
            res_illegal <= 1'b0;
        end
        else
        begin
            res_valid <= (next_state == opdec_pkg::st_done);
            if (next_state == opdec_pkg::st_done && state != opdec_pkg::st_done)
            begin
                res_illegal <= refuse;
                res_is_imm  <= (cur_mode == opdec_pkg::mode_immediate) && !refuse;
                res_is_addr <= (cur_mode != opdec_pkg::mode_inherent) && (cur_mode != opdec_pkg::mode_immediate)
                               && !refuse;
                res_imm     <= loc_now;
                res_addr    <= eff_addr;
            end
        end
    end

    // Mask level and oscillator stop take effect on the opcode itself;
    // leaving halt is up to the core's wake-up logic via reset
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_mask <= `MASK_LEVEL_SET;
            osc_stop <= 1'b0;
        end
        else if (take_op && op_mode == opdec_pkg::mode_inherent)
        begin
            if (op_inh == opdec_pkg::mask_set_op)
                int_mask <= `MASK_LEVEL_SET;
            else if (op_inh == opdec_pkg::mask_clear_op)
                int_mask <= `MASK_LEVEL_CLEAR;
            if (op_inh == opdec_pkg::halt_op)
                osc_stop <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** inc/opdec_defines.svh ***
`ifndef OPDEC_DEFINES_SVH
`define OPDEC_DEFINES_SVH
`define MASK_LEVEL_SET   2'h3
`define MASK_LEVEL_CLEAR 2'h0
`define PAGE_ZERO_HI     8'h00
`define BYTE_ZERO        8'h00
`define ADDR_ZERO        16'h0000
`define PTR_NEXT         16'h0001
`endif

// *** inc/opdec_pkg.sv ***
`default_nettype none
package opdec_pkg;
    // Addressing mode of the opcode just taken
    typedef enum logic [3:0] {
        mode_inherent,
        mode_immediate,
        mode_dir_short,
        mode_dir_long,
        mode_idx_none,
        mode_idx_short,
        mode_idx_long,
        mode_ind_short,
        mode_ind_long
    } addr_mode_t;
    // Inherent operations, plain or with a side effect here
    typedef enum logic [1:0] {
        op_plain,
        mask_set_op,
        mask_clear_op,
        halt_op
    } inh_op_t;
    typedef enum logic [2:0] {
        st_idle,
        st_byte1,
        st_byte2,
        st_ptr_hi,
        st_ptr_lo,
        st_done
    } dec_state_t;
endpackage
`default_nettype wire

// *** rtl/word_assemble.sv ***
`default_nettype none
`include "opdec_defines.svh"
// Joins two bytes into a word, first byte high
module word_assemble (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Byte strobes
    input  wire logic        load_hi,
    input  wire logic        load_lo,
    input  wire logic [7:0]  data_in,
    // Assembled word
    output logic      [15:0] word_out
);
    // High byte first, low byte second
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            word_out <= `ADDR_ZERO;
        else if (load_hi)
            word_out <= {data_in, `BYTE_ZERO};
        else if (load_lo)
            word_out <= {word_out[15:8], data_in};
    end
endmodule
`default_nettype wire

// *** bench/opdec_assertions.sv ***
`default_nettype none
module opdec_assertions (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // Opcode and byte handshakes
    input wire logic                  op_valid,
    input wire logic                  op_ready,
    input wire opdec_pkg::addr_mode_t op_mode,
    input wire opdec_pkg::inh_op_t    op_inh,
    input wire logic                  op_rmw,
    input wire logic                  byte_ready,
    // Pointer read and results
    input wire logic                  ptr_req,
    input wire logic                  ptr_ack,
    input wire logic                  res_valid,
    input wire logic                  res_is_addr,
    input wire logic                  res_illegal,
    input wire logic [1:0]            int_mask,
    input wire logic                  osc_stop
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Opcode taken this edge, split by class
    wire take = op_valid && op_ready;
    wire inh  = take && op_mode == opdec_pkg::mode_inherent;
    wire bad  = take && op_rmw && op_mode inside {opdec_pkg::mode_immediate, opdec_pkg::mode_dir_long,
                                                  opdec_pkg::mode_idx_long, opdec_pkg::mode_ind_long};
    // Result shapes
    sequence addr_res_s;
        res_valid && res_is_addr && !res_illegal;
    endsequence
    sequence refused_s;
        res_valid && res_illegal && !res_is_addr;
    endsequence
    inh_len_a: assert property (inh |=> res_valid && !byte_ready)
        else $error("inherent op fetched bytes");
    mask_set_a: assert property (inh && op_inh == opdec_pkg::mask_set_op |=> int_mask == 2'h3)
        else $error("mask not raised");
    mask_clear_a: assert property (inh && op_inh == opdec_pkg::mask_clear_op |=> int_mask == 2'h0)
        else $error("mask not lowered");
    halt_stop_a: assert property (inh && op_inh == opdec_pkg::halt_op |=> osc_stop [*4])
        else $error("oscillator not stopped");
    imm_byte_a: assert property (take && op_mode == opdec_pkg::mode_immediate && !op_rmw |=> byte_ready)
        else $error("literal byte not fetched");
    idx_none_a: assert property (take && op_mode == opdec_pkg::mode_idx_none |=> addr_res_s)
        else $error("no-offset index fetched bytes");
    rmw_refuse_a: assert property (bad |=> refused_s ##1 op_ready)
        else $error("long mode accepted for rmw");
    ptr_wait_a: assert property (ptr_req && !ptr_ack |=> ptr_req && !res_valid)
        else $error("result before pointer read");
endmodule
bind cpu_operand_address_decoder opdec_assertions opdec_assertions_inst (.*);
`default_nettype wire

// *** bench/ptr_mem_model.sv ***
`default_nettype none
// Data memory answering pointer reads after a chosen wait
module ptr_mem_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Wait cycles before each answer
    input  wire logic [1:0]  wait_cyc,
    // Pointer read port
    input  wire logic        ptr_req,
    input  wire logic [15:0] ptr_addr,
    output logic             ptr_ack,
    output logic [7:0]       ptr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt;
    // Outside an answer the data is inverted every cycle, so a stale byte reads back unchanged on alternate cycles
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ptr_ack  <= 1'b0;
            ptr_data <= 8'h00;
            cnt      <= 2'h0;
        end
        else
        begin
            ptr_ack  <= ptr_req && !ptr_ack && cnt == wait_cyc;
            ptr_data <= (ptr_req && !ptr_ack && cnt == wait_cyc) ? ptr_addr[7:0] ^ ptr_addr[15:8] ^ 8'ha5 : ~ptr_data;
            cnt      <= (ptr_req && !ptr_ack && cnt != wait_cyc) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst, op_valid, op_ready, op_rmw, op_use_y, byte_valid, byte_ready, ptr_req, ptr_ack;
    logic res_valid, res_is_imm, res_is_addr, res_illegal, osc_stop;
    logic [1:0]  int_mask, wait_cyc;
    logic [7:0]  byte_data, index_x, index_y, ptr_data, res_imm;
    logic [15:0] ptr_addr, res_addr;
    opdec_pkg::addr_mode_t op_mode;
    opdec_pkg::inh_op_t    op_inh;
    int miscompares, checks_done, takes;
    localparam opdec_pkg::inh_op_t plain = opdec_pkg::op_plain;
    cpu_operand_address_decoder cpu_operand_address_decoder_inst (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .op_valid    (op_valid),
        .op_ready    (op_ready),
        .op_mode     (op_mode),
        .op_inh      (op_inh),
        .op_rmw      (op_rmw),
        .op_use_y    (op_use_y),
        .byte_valid  (byte_valid),
        .byte_ready  (byte_ready),
        .byte_data   (byte_data),
        .index_x     (index_x),
        .index_y     (index_y),
        .ptr_req     (ptr_req),
        .ptr_addr    (ptr_addr),
        .ptr_ack     (ptr_ack),
        .ptr_data    (ptr_data),
        .res_valid   (res_valid),
        .res_is_imm  (res_is_imm),
        .res_is_addr (res_is_addr),
        .res_addr    (res_addr),
        .res_imm     (res_imm),
        .res_illegal (res_illegal),
        .int_mask    (int_mask),
        .osc_stop    (osc_stop)
    );
    ptr_mem_model ptr_mem_model_inst (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wait_cyc (wait_cyc),
        .ptr_req  (ptr_req),
        .ptr_addr (ptr_addr),
        .ptr_ack  (ptr_ack),
        .ptr_data (ptr_data)
    );
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Bytes the decoder takes, counted at the taking edge itself
    always @(posedge clk)
    begin
        if (byte_valid && byte_ready)
            takes++;
    end
    task automatic wrap_up;
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction
    // One instruction: opcode, n operand bytes high first, then the result
    task automatic run(input opdec_pkg::addr_mode_t m, input logic [15:0] w, input int n,
                       input opdec_pkg::inh_op_t h = plain, input logic r = 1'b0);
        int k;
        takes = 0;
        for (k = 0; k < 20 && op_ready !== 1'b1; k++) @(negedge clk);
        check(32'(op_ready), 32'h00000001);
        op_mode = m;
        op_inh = h;
        op_rmw = r;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        for (int i = n; i > 0; i--)
        begin
            for (k = 0; k < 20 && byte_ready !== 1'b1; k++) @(negedge clk);
            check(32'(byte_ready), 32'h00000001);
            byte_data = (i == 2) ? w[15:8] : w[7:0];
            byte_valid = 1'b1;
            @(negedge clk);
        end
        byte_valid = 1'b0;
        for (k = 0; k < 30 && res_valid !== 1'b1; k++) @(negedge clk);
        check(32'(res_valid), 32'h00000001);
        check(32'(takes), 32'(n));
    endtask
    task automatic t_immediate;
        run(opdec_pkg::mode_immediate, 16'h00c3, 1);
        check(32'({res_is_imm, res_is_addr, res_imm}), 32'h000002c3);
    endtask
    task automatic t_direct;
        run(opdec_pkg::mode_dir_short, 16'h00ff, 1);
        check(32'(res_addr), 32'h000000ff);
        run(opdec_pkg::mode_dir_long, 16'h1234, 2);
        check(32'(res_addr), 32'h00001234);
    endtask
    // Index sums at the wrap boundaries
    task automatic t_indexed;
        {index_x, index_y, op_use_y} = {8'h9c, 8'hff, 1'b0};
        run(opdec_pkg::mode_idx_none, 16'h0000, 0);
        check(32'(res_addr), 32'h0000009c);
        op_use_y = 1'b1;
        run(opdec_pkg::mode_idx_short, 16'h00ff, 1);
        check(32'(res_addr), 32'h000001fe);
        {index_x, op_use_y} = {8'h20, 1'b0};
        run(opdec_pkg::mode_idx_long, 16'hfff0, 2);
        check(32'(res_addr), 32'h00000010);
    endtask
    // Slow memory for the byte pointer, prompt for the word pointer
    task automatic t_indirect;
        wait_cyc = 2'h3;
        run(opdec_pkg::mode_ind_short, 16'h0040, 1);
        check(32'(res_addr), 32'({8'h00, mem(16'h0040)}));
        wait_cyc = 2'h0;
        run(opdec_pkg::mode_ind_long, 16'h0040, 1);
        check(32'(res_addr), 32'({mem(16'h0040), mem(16'h0041)}));
    endtask
    task automatic t_rmw;
        opdec_pkg::addr_mode_t lm[4] = '{opdec_pkg::mode_immediate, opdec_pkg::mode_dir_long,
                                         opdec_pkg::mode_idx_long, opdec_pkg::mode_ind_long};
        foreach (lm[i])
        begin
            run(lm[i], 16'h0000, 0, plain, 1'b1);
            check(32'({res_illegal, res_is_addr}), 32'h00000002);
        end
        run(opdec_pkg::mode_dir_short, 16'h0012, 1, plain, 1'b1);
        check(32'({res_illegal, res_addr}), 32'h00000012);
    endtask
    task automatic t_inherent;
        opdec_pkg::inh_op_t ops[4] = '{opdec_pkg::mask_clear_op, plain, opdec_pkg::mask_set_op,
                                       opdec_pkg::mask_clear_op};
        logic [1:0] lvl[4] = '{2'h0, 2'h0, 2'h3, 2'h0};
        foreach (ops[i])
        begin
            run(opdec_pkg::mode_inherent, 16'h0000, 0, ops[i]);
            check(32'(int_mask), 32'(lvl[i]));
        end
        run(opdec_pkg::mode_inherent, 16'h0000, 0, opdec_pkg::halt_op);
        check(32'(osc_stop), 32'h00000001);
    endtask
    // Watchdog: 2000 cycles, far beyond the hundred or fewer cycles the run needs
    initial
    begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial
    begin
        {sys_rst, op_valid, op_rmw, op_use_y, byte_valid} = 5'h10;
        op_mode = opdec_pkg::mode_inherent;
        op_inh = plain;
        {byte_data, index_x, index_y, wait_cyc} = 26'h0;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        t_immediate();
        t_direct();
        t_indexed();
        t_indirect();
        t_rmw();
        t_inherent();
        wrap_up();
    end
endmodule
`default_nettype wire
